// ==== core/fsd_decoder.sv ====
// FPU store, subtract, compare and log instruction decoder and sequencer
// Function
// - Register store-and-pop copies top into register n, pops, 2 clocks.
// - Extended real memory store then pop, 2 clocks.
// - Double and single real memory store then pop, 2 clocks each.
// - Packed decimal store then pop, 57 to 63 clocks.
// - Integer store without pop: 32-bit 8-13, 16-bit 7-10 clocks.
// - Integer store with pop: 64-bit 10-13, 32 and 16 bit as above.
// - Control word store 3 clocks, 5 with wait prefix.
// - Environment store 12-22 clocks, 14-24 with wait prefix.
// - Status word store 4 clocks, 6 with wait prefix.
// - Status word to accumulator 2 clocks, 4 with wait prefix.
// - Real subtract forms, 4 to 9 clocks, pop form pops once.
// - Reverse real subtract forms, 4 to 9 clocks, pop form pops.
// - Integer subtract: 32-bit 14-29, 16-bit 14-27 clocks.
// - Reverse integer subtract, same clock ranges as forward.
// - Compare top with zero sets condition bits, 4 clocks.
// - Unordered compare 4 clocks, pop form pops once.
// - Compare with register one then pop twice, 4 clocks.
// - Wait opcode stalls until unit not busy, then 2 clocks.
// - Classify top into condition bits, 4 clocks.
// - Exchange top with register n, 3 clocks.
// - Split exponent: replace top, push significand, 11-16 clocks.
// - Scaled logs into register one then pop: 145-154 or 131-133.
// - Push decrements top pointer, pop increments; operands pre-execution.
// - Log-plus-one argument out of range falls back, 170 clocks.
`timescale 1ns/1ps
module fsd_decoder #(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue from the integer unit
  input wire logic issue_valid,
  input wire logic [7:0] issue_opcode,
  input wire logic [7:0] issue_modrm,
  input wire logic issue_wait,
  input wire logic [CNT_W-1:0] issue_extra,
  input wire logic arg_out_of_range,
  output logic issue_ready_q,
  output logic reject_q,
  // Floating-point unit state
  input wire logic unit_busy,
  // Completion
  output logic done_q,
  output fsd_pkg::fsd_op_t done_op_q,
  output logic [2:0] stack_reg_n_q,
  output logic [2:0] stack_top_q,
  output logic mem_store_q,
  output logic condition_code_load_q,
  output logic acc_load_q
);
  import fsd_pkg::*;

  // ==========================================================
  // Elaboration check: counts up to 170 need eight bits
  if (CNT_W < 8)
  begin : g_bad_width
    $error("fsd_decoder: CNT_W must be at least 8");
  end

  // ==========================================================
  // Decoding functions
  // Opcode and modrm into an operation code
  function automatic fsd_op_t decode_op(input logic [7:0] opc,
                                        input logic [7:0] mrm);
    logic is_reg;
    logic [4:0] rf;
    logic [2:0] rg;
    fsd_op_t op;
    is_reg = (mrm[7:6] == MOD_REG);
    rf = mrm[7:3];
    rg = mrm[5:3];
    op = OP_ILLEGAL;
    case (opc)
      OPC_DB:
        if (is_reg && rf == RF_STORE_POP) op = OP_STORE_REAL_POP_REG;
        else if (!is_reg && rg == RG_7) op = OP_STORE_EXT_POP;
        else if (!is_reg && rg == RG_2) op = OP_STORE_INT32;
        else if (!is_reg && rg == RG_3) op = OP_STORE_INT32_POP;
      OPC_DD:
        if (is_reg && rf == RF_E0) op = OP_UNORDERED_COMPARE;
        else if (is_reg && rf == RF_E1) op = OP_UNORDERED_COMPARE_POP;
        else if (!is_reg && rg == RG_3) op = OP_STORE_DBL_POP;
        else if (!is_reg && rg == RG_7) op = OP_STORE_STATUS;
      OPC_D9:
        if (mrm == MRM_TEST_ZERO) op = OP_COMPARE_WITH_ZERO;
        else if (mrm == MRM_CLASSIFY) op = OP_CLASSIFY_OPERAND;
        else if (mrm == MRM_SPLIT) op = OP_SPLIT_EXPONENT;
        else if (mrm == MRM_LOG2) op = OP_SCALED_LOG2;
        else if (mrm == MRM_LOG2P1) op = OP_SCALED_LOG2_PLUS_ONE;
        else if (is_reg && rf == RF_XCHG) op = OP_EXCHANGE_WITH_TOP;
        else if (!is_reg && rg == RG_3) op = OP_STORE_SGL_POP;
        else if (!is_reg && rg == RG_7) op = OP_STORE_CONTROL_WORD;
        else if (!is_reg && rg == RG_6) op = OP_STORE_ENVIRONMENT;
      OPC_DF:
        if (mrm == MRM_STATUS_ACC) op = OP_STORE_STATUS_ACC;
        else if (!is_reg && rg == RG_6) op = OP_STORE_DECIMAL_POP;
        else if (!is_reg && rg == RG_2) op = OP_STORE_INT16;
        else if (!is_reg && rg == RG_7) op = OP_STORE_INT64_POP;
        else if (!is_reg && rg == RG_3) op = OP_STORE_INT16_POP;
      OPC_DC:
        if (is_reg && rf == RF_E1) op = OP_SUB_INTO_REG;
        else if (is_reg && rf == RF_E0) op = OP_SUBR_INTO_TOP;
        else if (!is_reg && rg == RG_4) op = OP_SUB_DBL;
        else if (!is_reg && rg == RG_5) op = OP_SUBR_DBL;
      OPC_D8:
        if (is_reg && rf == RF_E0) op = OP_SUB_INTO_TOP;
        else if (is_reg && rf == RF_E1) op = OP_SUBR_INTO_REG;
        else if (!is_reg && rg == RG_4) op = OP_SUB_SGL;
        else if (!is_reg && rg == RG_5) op = OP_SUBR_SGL;
      OPC_DE:
        if (is_reg && rf == RF_E1) op = OP_SUB_POP;
        else if (is_reg && rf == RF_E0) op = OP_SUBR_POP;
        else if (!is_reg && rg == RG_4) op = OP_ISUB16;
        else if (!is_reg && rg == RG_5) op = OP_ISUBR16;
      OPC_DA:
        if (mrm == MRM_CMP_POP2) op = OP_UNORDERED_COMPARE_POP_TWICE;
        else if (!is_reg && rg == RG_4) op = OP_ISUB32;
        else if (!is_reg && rg == RG_5) op = OP_ISUBR32;
      OPC_WAIT: op = OP_WAIT_NOT_BUSY;
      default: op = OP_ILLEGAL;
    endcase
    return op;
  endfunction : decode_op

  // Least and most clocks as {min, max}
  function automatic logic [15:0] clock_span(input fsd_op_t op,
                                             input logic w,
                                             input logic oor);
    case (op)
      OP_STORE_REAL_POP_REG, OP_STORE_EXT_POP, OP_STORE_DBL_POP,
      OP_STORE_SGL_POP: return {C_STORE, C_STORE};
      OP_STORE_DECIMAL_POP: return {C_BCD_MIN, C_BCD_MAX};
      OP_STORE_INT32, OP_STORE_INT32_POP:
        return {C_I32_MIN, C_I32_MAX};
      OP_STORE_INT16, OP_STORE_INT16_POP:
        return {C_I16_MIN, C_I16_MAX};
      OP_STORE_INT64_POP: return {C_I64_MIN, C_I64_MAX};
      OP_STORE_CONTROL_WORD:
        return w ? {C_CW_W, C_CW_W} : {C_CW, C_CW};
      OP_STORE_ENVIRONMENT:
        return w ? {C_ENV_W_MIN, C_ENV_W_MAX} : {C_ENV_MIN, C_ENV_MAX};
      OP_STORE_STATUS:
        return w ? {C_SW_W, C_SW_W} : {C_SW, C_SW};
      OP_STORE_STATUS_ACC:
        return w ? {C_ACC_W, C_ACC_W} : {C_ACC, C_ACC};
      OP_ISUB32, OP_ISUBR32:
        return {C_ISUB_MIN, C_ISUB32_MAX};
      OP_ISUB16, OP_ISUBR16:
        return {C_ISUB_MIN, C_ISUB16_MAX};
      OP_COMPARE_WITH_ZERO, OP_UNORDERED_COMPARE,
      OP_UNORDERED_COMPARE_POP, OP_UNORDERED_COMPARE_POP_TWICE,
      OP_CLASSIFY_OPERAND: return {C_CMP, C_CMP};
      OP_WAIT_NOT_BUSY: return {C_WAIT, C_WAIT};
      OP_EXCHANGE_WITH_TOP: return {C_XCHG, C_XCHG};
      OP_SPLIT_EXPONENT: return {C_SPLIT_MIN, C_SPLIT_MAX};
      OP_SCALED_LOG2: return {C_LOG_MIN, C_LOG_MAX};
      OP_SCALED_LOG2_PLUS_ONE:
        return oor ? {C_LOGP1_OOR, C_LOGP1_OOR} : {C_LOGP1_MIN, C_LOGP1_MAX};
      default: return {C_SUB_MIN, C_SUB_MAX};
    endcase
  endfunction : clock_span

  // Effects {pops[1:0], push, mem store, condition load, acc load}
  function automatic logic [5:0] op_effect(input fsd_op_t op);
    case (op)
      OP_STORE_REAL_POP_REG, OP_SUB_POP, OP_SUBR_POP,
      OP_SCALED_LOG2, OP_SCALED_LOG2_PLUS_ONE: return 6'h10;
      OP_STORE_EXT_POP, OP_STORE_DBL_POP, OP_STORE_SGL_POP,
      OP_STORE_DECIMAL_POP, OP_STORE_INT64_POP, OP_STORE_INT32_POP,
      OP_STORE_INT16_POP: return 6'h14;
      OP_STORE_INT32, OP_STORE_INT16, OP_STORE_CONTROL_WORD,
      OP_STORE_ENVIRONMENT, OP_STORE_STATUS: return 6'h04;
      OP_STORE_STATUS_ACC: return 6'h01;
      OP_COMPARE_WITH_ZERO, OP_UNORDERED_COMPARE,
      OP_CLASSIFY_OPERAND: return 6'h02;
      OP_UNORDERED_COMPARE_POP: return 6'h12;
      OP_UNORDERED_COMPARE_POP_TWICE: return 6'h22;
      OP_SPLIT_EXPONENT: return 6'h08;
      default: return 6'h00;
    endcase
  endfunction : op_effect

  // ==========================================================
  // Issue decode and length selection
  fsd_state_t state_q;
  fsd_op_t op_q;
  fsd_op_t dec_op;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] len_q;
  logic wait_q;
  logic oor_q;
  logic dec_wait;
  logic dec_bad;
  logic fire;
  logic [15:0] dec_span;
  logic [CNT_W-1:0] dec_min;
  logic [CNT_W-1:0] dec_rng;
  logic [CNT_W-1:0] dec_len;
  logic [5:0] eff;
  logic [2:0] top_d;
  logic last;

  assign dec_op = decode_op(issue_opcode, issue_modrm);
  assign dec_bad = (dec_op == OP_ILLEGAL);
  assign dec_wait = issue_wait | (dec_op == OP_WAIT_NOT_BUSY);
  assign dec_span = clock_span(dec_op, issue_wait, arg_out_of_range);
  assign dec_min = CNT_W'(dec_span[15:8]);
  assign dec_rng = CNT_W'(dec_span[7:0]) - dec_min;
  // Data-dependent extra clocks, clamped so the range is never exceeded
  assign dec_len = dec_min + ((issue_extra > dec_rng) ? dec_rng : issue_extra);
  assign fire = issue_valid & issue_ready_q;

  // Completion effects; pointer moves once, at the end
  assign eff = op_effect(op_q);
  assign top_d = stack_top_q + {1'b0, eff[5:4]} - {2'b00, eff[3]};
  assign last = (state_q == ST_EXEC) && (cnt_q == CNT_W'(1));

  // ==========================================================
  // Sequencer: accept, optional wait for idle unit, then count down
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_IDLE;
      issue_ready_q <= 1'b0;
      reject_q <= 1'b0;
      op_q <= OP_ILLEGAL;
      cnt_q <= '0;
      len_q <= '0;
      wait_q <= 1'b0;
      oor_q <= 1'b0;
      stack_reg_n_q <= 3'h0;
    end
    else
    begin
      reject_q <= fire & dec_bad;
      case (state_q)
        ST_IDLE:
        begin
          issue_ready_q <= 1'b1;
          if (fire && !dec_bad)
          begin
            op_q <= dec_op;
            stack_reg_n_q <= issue_modrm[2:0];
            cnt_q <= dec_len - CNT_W'(1);
            len_q <= CNT_W'(1);
            wait_q <= dec_wait;
            oor_q <= arg_out_of_range;
            issue_ready_q <= 1'b0;
            state_q <= dec_wait ? ST_WAIT : ST_EXEC;
          end
        end
        // Hold until the rest of the unit has drained
        ST_WAIT:
          if (!unit_busy) state_q <= ST_EXEC;
        ST_EXEC:
        begin
          len_q <= len_q + CNT_W'(1);
          cnt_q <= cnt_q - CNT_W'(1);
          if (last)
          begin
            state_q <= ST_IDLE;
            issue_ready_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Completion outputs, one-cycle pulses plus the held operation code and stack pointer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      done_q <= 1'b0;
      done_op_q <= OP_ILLEGAL;
      stack_top_q <= 3'h0;
      mem_store_q <= 1'b0;
      condition_code_load_q <= 1'b0;
      acc_load_q <= 1'b0;
    end
    else
    begin
      done_q <= last;
      mem_store_q <= last & eff[2];
      condition_code_load_q <= last & eff[1];
      acc_load_q <= last & eff[0];
      if (last)
      begin
        done_op_q <= op_q;
        stack_top_q <= top_d;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_REG_STORE_POP: assert property (
    fire && dec_op == OP_STORE_REAL_POP_REG && !dec_wait |-> ##2
      done_q && stack_top_q == 3'($past(stack_top_q) + 3'h1))
    else $error("register store-pop not done in 2 clocks with pop");
  AST_EXT_STORE_LEN: assert property (
    done_q && done_op_q == OP_STORE_EXT_POP |->
      len_q == CNT_W'(C_STORE) && $past(mem_store_q) == 1'b0 && mem_store_q)
    else $error("extended store length or store strobe wrong");
  AST_DECIMAL_LEN: assert property (
    done_q && done_op_q == OP_STORE_DECIMAL_POP |->
      len_q >= CNT_W'(C_BCD_MIN) && len_q <= CNT_W'(C_BCD_MAX))
    else $error("decimal store length outside 57 to 63");
  AST_INT16_LEN: assert property (
    done_q && done_op_q == OP_STORE_INT16 |->
      len_q >= CNT_W'(C_I16_MIN) && len_q <= CNT_W'(C_I16_MAX)
      && stack_top_q == $past(stack_top_q))
    else $error("word integer store length or pointer wrong");
  AST_CTRL_WORD_LEN: assert property (
    done_q && done_op_q == OP_STORE_CONTROL_WORD |->
      len_q == (wait_q ? CNT_W'(C_CW_W) : CNT_W'(C_CW)))
    else $error("control word store length wrong");
  AST_STATUS_LEN: assert property (
    done_q && done_op_q == OP_STORE_STATUS |->
      len_q == (wait_q ? CNT_W'(C_SW_W) : CNT_W'(C_SW)))
    else $error("status word store length wrong");
  AST_POP_TWICE: assert property (
    fire && dec_op == OP_UNORDERED_COMPARE_POP_TWICE && !dec_wait |=>
      !done_q [*3] ##1 done_q && condition_code_load_q
      && stack_top_q == 3'($past(stack_top_q, 3) + 3'h2))
    else $error("double pop compare not done in 4 clocks");
  AST_WAIT_STALL: assert property (
    state_q == ST_WAIT && unit_busy |=> state_q == ST_WAIT && !done_q)
    else $error("wait left while unit still busy");
  AST_SPLIT_PUSH: assert property (
    done_q && done_op_q == OP_SPLIT_EXPONENT |->
      stack_top_q == 3'($past(stack_top_q) - 3'h1))
    else $error("split exponent did not push");
  AST_LOGP1_FALLBACK: assert property (
    done_q && done_op_q == OP_SCALED_LOG2_PLUS_ONE && oor_q |->
      len_q == CNT_W'(C_LOGP1_OOR))
    else $error("log plus one fallback not 170 clocks");

  CV_WAITED_STORE: cover property (
    done_q && done_op_q == OP_STORE_ENVIRONMENT && wait_q);
  CV_REJECT: cover property (reject_q);
  CV_BACK_TO_BACK: cover property (done_q ##1 fire);

endmodule : fsd_decoder

// ==== core/fsd_pkg.sv ====
// Constants, opcode encodings and types for the FPU store/subtract decoder
package fsd_pkg;

  // ==========================================================
  // Opcode bytes and modrm fields
  localparam logic [7:0] OPC_D8 = 8'hD8;
  localparam logic [7:0] OPC_D9 = 8'hD9;
  localparam logic [7:0] OPC_DA = 8'hDA;
  localparam logic [7:0] OPC_DB = 8'hDB;
  localparam logic [7:0] OPC_DC = 8'hDC;
  localparam logic [7:0] OPC_DD = 8'hDD;
  localparam logic [7:0] OPC_DE = 8'hDE;
  localparam logic [7:0] OPC_DF = 8'hDF;
  localparam logic [7:0] OPC_WAIT = 8'h9B;
  // Second bytes of the fixed two-byte forms
  localparam logic [7:0] MRM_TEST_ZERO = 8'hE4;
  localparam logic [7:0] MRM_CLASSIFY = 8'hE5;
  localparam logic [7:0] MRM_SPLIT = 8'hF4;
  localparam logic [7:0] MRM_LOG2 = 8'hF1;
  localparam logic [7:0] MRM_LOG2P1 = 8'hF9;
  localparam logic [7:0] MRM_STATUS_ACC = 8'hE0;
  localparam logic [7:0] MRM_CMP_POP2 = 8'hE9;
  // Register-form patterns on modrm[7:3]
  localparam logic [4:0] RF_STORE_POP = 5'h1B;
  localparam logic [4:0] RF_XCHG = 5'h19;
  localparam logic [4:0] RF_E0 = 5'h1C;
  localparam logic [4:0] RF_E1 = 5'h1D;
  localparam logic [1:0] MOD_REG = 2'h3;
  // Memory-form reg field values
  localparam logic [2:0] RG_2 = 3'h2;
  localparam logic [2:0] RG_3 = 3'h3;
  localparam logic [2:0] RG_4 = 3'h4;
  localparam logic [2:0] RG_5 = 3'h5;
  localparam logic [2:0] RG_6 = 3'h6;
  localparam logic [2:0] RG_7 = 3'h7;

  // ==========================================================
  // Clock counts, least and most
  localparam logic [7:0] C_STORE = 8'h02;
  localparam logic [7:0] C_BCD_MIN = 8'h39;
  localparam logic [7:0] C_BCD_MAX = 8'h3F;
  localparam logic [7:0] C_I32_MIN = 8'h08;
  localparam logic [7:0] C_I32_MAX = 8'h0D;
  localparam logic [7:0] C_I16_MIN = 8'h07;
  localparam logic [7:0] C_I16_MAX = 8'h0A;
  localparam logic [7:0] C_I64_MIN = 8'h0A;
  localparam logic [7:0] C_I64_MAX = 8'h0D;
  localparam logic [7:0] C_CW = 8'h03;
  localparam logic [7:0] C_CW_W = 8'h05;
  localparam logic [7:0] C_ENV_MIN = 8'h0C;
  localparam logic [7:0] C_ENV_MAX = 8'h16;
  localparam logic [7:0] C_ENV_W_MIN = 8'h0E;
  localparam logic [7:0] C_ENV_W_MAX = 8'h18;
  localparam logic [7:0] C_SW = 8'h04;
  localparam logic [7:0] C_SW_W = 8'h06;
  localparam logic [7:0] C_ACC = 8'h02;
  localparam logic [7:0] C_ACC_W = 8'h04;
  localparam logic [7:0] C_SUB_MIN = 8'h04;
  localparam logic [7:0] C_SUB_MAX = 8'h09;
  localparam logic [7:0] C_ISUB_MIN = 8'h0E;
  localparam logic [7:0] C_ISUB32_MAX = 8'h1D;
  localparam logic [7:0] C_ISUB16_MAX = 8'h1B;
  localparam logic [7:0] C_CMP = 8'h04;
  localparam logic [7:0] C_WAIT = 8'h02;
  localparam logic [7:0] C_XCHG = 8'h03;
  localparam logic [7:0] C_SPLIT_MIN = 8'h0B;
  localparam logic [7:0] C_SPLIT_MAX = 8'h10;
  localparam logic [7:0] C_LOG_MIN = 8'h91;
  localparam logic [7:0] C_LOG_MAX = 8'h9A;
  localparam logic [7:0] C_LOGP1_MIN = 8'h83;
  localparam logic [7:0] C_LOGP1_MAX = 8'h85;
  localparam logic [7:0] C_LOGP1_OOR = 8'hAA;

  // ==========================================================
  // Operation codes reported on completion
  typedef enum logic [5:0] {
    OP_ILLEGAL = 6'h00,
    OP_STORE_REAL_POP_REG = 6'h01,
    OP_STORE_EXT_POP = 6'h02,
    OP_STORE_DBL_POP = 6'h03,
    OP_STORE_SGL_POP = 6'h04,
    OP_STORE_DECIMAL_POP = 6'h05,
    OP_STORE_INT32 = 6'h06,
    OP_STORE_INT16 = 6'h07,
    OP_STORE_INT64_POP = 6'h08,
    OP_STORE_INT32_POP = 6'h09,
    OP_STORE_INT16_POP = 6'h0A,
    OP_STORE_CONTROL_WORD = 6'h0B,
    OP_STORE_ENVIRONMENT = 6'h0C,
    OP_STORE_STATUS = 6'h0D,
    OP_STORE_STATUS_ACC = 6'h0E,
    OP_SUB_INTO_REG = 6'h0F,
    OP_SUB_INTO_TOP = 6'h10,
    OP_SUB_DBL = 6'h11,
    OP_SUB_SGL = 6'h12,
    OP_SUB_POP = 6'h13,
    OP_SUBR_INTO_TOP = 6'h14,
    OP_SUBR_INTO_REG = 6'h15,
    OP_SUBR_DBL = 6'h16,
    OP_SUBR_SGL = 6'h17,
    OP_SUBR_POP = 6'h18,
    OP_ISUB32 = 6'h19,
    OP_ISUB16 = 6'h1A,
    OP_ISUBR32 = 6'h1B,
    OP_ISUBR16 = 6'h1C,
    OP_COMPARE_WITH_ZERO = 6'h1D,
    OP_UNORDERED_COMPARE = 6'h1E,
    OP_UNORDERED_COMPARE_POP = 6'h1F,
    OP_UNORDERED_COMPARE_POP_TWICE = 6'h20,
    OP_WAIT_NOT_BUSY = 6'h21,
    OP_CLASSIFY_OPERAND = 6'h22,
    OP_EXCHANGE_WITH_TOP = 6'h23,
    OP_SPLIT_EXPONENT = 6'h24,
    OP_SCALED_LOG2 = 6'h25,
    OP_SCALED_LOG2_PLUS_ONE = 6'h26
  } fsd_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_EXEC = 2'b10
  } fsd_state_t;

endpackage : fsd_pkg

// ==== verification/fsd_iu_model.sv ====
// Integer-unit model that offers instructions to the decoder
`timescale 1ns/1ps
module fsd_iu_model (
  // Clock
  input wire logic clk,
  // Issue handshake
  output logic issue_valid,
  output logic [7:0] issue_opcode,
  output logic [7:0] issue_modrm,
  output logic issue_wait,
  output logic [7:0] issue_extra,
  output logic arg_out_of_range,
  input wire logic issue_ready_q
);
  // ==========================================================
  // Idle state
  initial
  begin
    issue_valid = 1'b0;
    {issue_opcode, issue_modrm, issue_extra} = 24'h00_0000;
    {issue_wait, arg_out_of_range} = 2'h0;
  end

  // ==========================================================
  // Offer after gap cycles, hold until the taking edge, then scramble
  // the released lines so a stale copy can never pass for a request
  task automatic send(input logic [7:0] opc, input logic [7:0] mrm,
    input logic w, input logic [7:0] ext, input logic oor, input int gap);
    repeat (gap)
    begin
      @(posedge clk);
      #1;
    end
    issue_valid = 1'b1;
    {issue_opcode, issue_modrm, issue_extra} = {opc, mrm, ext};
    {issue_wait, arg_out_of_range} = {w, oor};
    do @(posedge clk); while (issue_ready_q !== 1'b1);
    #1;
    issue_valid = 1'b0;
    {issue_opcode, issue_modrm, issue_extra} = ~{opc, mrm, ext};
    {issue_wait, arg_out_of_range} = ~{w, oor};
  endtask : send
endmodule : fsd_iu_model

// ==== verification/tb.sv ====
// Self-checking bench for the FPU store/subtract decoder
`timescale 1ns/1ps
module tb;
  import fsd_pkg::*;
  // ==========================================================
  // Signals and bookkeeping
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic unit_busy = 1'b0;
  logic issue_valid, issue_wait, arg_out_of_range, issue_ready_q;
  logic [7:0] issue_opcode, issue_modrm, issue_extra;
  logic reject_q, done_q, mem_store_q, condition_code_load_q, acc_load_q;
  fsd_op_t done_op_q;
  logic [2:0] stack_reg_n_q, stack_top_q;
  logic [2:0] top_exp;
  int failures = 0;
  int check_count = 0;
  // Flags: bit 7 waited count adds two, 6 acc, 5 cc, 4 mem, 2:0 pops
  typedef struct packed {
    logic [7:0] opc; logic [7:0] b; logic [7:0] lo; logic [7:0] hi;
    fsd_op_t op; logic [7:0] pf;
  } fsd_ent_t;
  fsd_ent_t tbl[$];
  // Undecodable and reserved two-byte codes
  logic [15:0] bad_code [4];

  always #2.5 clk = ~clk;

  fsd_iu_model i_iu (.clk(clk), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_modrm(issue_modrm),
    .issue_wait(issue_wait), .issue_extra(issue_extra),
    .arg_out_of_range(arg_out_of_range), .issue_ready_q(issue_ready_q));

  fsd_decoder i_dut (.clk(clk), .rst_b(rst_b), .issue_valid(issue_valid),
    .issue_opcode(issue_opcode), .issue_modrm(issue_modrm),
    .issue_wait(issue_wait), .issue_extra(issue_extra),
    .arg_out_of_range(arg_out_of_range), .issue_ready_q(issue_ready_q),
    .reject_q(reject_q), .unit_busy(unit_busy), .done_q(done_q),
    .done_op_q(done_op_q), .stack_reg_n_q(stack_reg_n_q),
    .stack_top_q(stack_top_q), .mem_store_q(mem_store_q),
    .condition_code_load_q(condition_code_load_q),
    .acc_load_q(acc_load_q));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic add(input logic [7:0] o, input logic [7:0] b,
    input logic [7:0] lo, input logic [7:0] hi, input fsd_op_t op,
    input logic [7:0] pf);
    tbl.push_back({o, b, lo, hi, op, pf});
  endtask : add

  // Reset is synchronous, so hold it over several edges
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({issue_ready_q, done_q, reject_q, stack_top_q}, 32'h0000_0000);
    chk(done_op_q, OP_ILLEGAL);
    rst_b = 1'b1;
    top_exp = 3'h0;
  endtask : do_reset

  // One instruction: build modrm, predict count and effects, compare
  task automatic run(input int i, input logic w, input logic [7:0] x,
    input logic oor, input int bk, input int gap);
    fsd_ent_t e;
    logic [7:0] m, r;
    logic we;
    int n, c;
    e = tbl[i];
    r = 8'($urandom);
    if (e.b[7:5] != 3'h0)
      m = e.b;
    else if (e.b[4])
      m = {e.b[4:0], r[2:0]};
    else
      m = {(r[7:6] == 2'h3) ? 2'h2 : r[7:6], e.b[2:0], r[2:0]};
    we = w | (e.opc == 8'h9b);
    n = e.lo + ((x > e.hi - e.lo) ? e.hi - e.lo : x);
    n = n + ((w && e.pf[7]) ? 2 : 0);
    if (oor && e.op == OP_SCALED_LOG2_PLUS_ONE)
      n = 170;
    unit_busy = we && (bk > 0);
    i_iu.send(e.opc, m, w, x, oor, gap);
    c = 0;
    while (done_q !== 1'b1 && c < 400)
    begin
      @(posedge clk);
      #1;
      c++;
      if (c == bk)
        unit_busy = 1'b0;
    end
    unit_busy = 1'b0;
    top_exp = top_exp + e.pf[2:0];
    chk(c, n - 1 + we + (we ? bk : 0));
    chk(done_op_q, e.op);
    chk(stack_top_q, top_exp);
    chk({acc_load_q, condition_code_load_q, mem_store_q}, e.pf[6:4]);
    chk({stack_reg_n_q, issue_ready_q}, {m[2:0], 1'b1});
  endtask : run

  // ==========================================================
  // Watchdog
  initial
  begin
    // Whole run needs a few thousand cycles; this allows ten times that
    #200us;
    failures++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    add(8'hdb, 8'h1b, 8'h02, 8'h02, OP_STORE_REAL_POP_REG, 8'h01);
    add(8'hdb, 8'h07, 8'h02, 8'h02, OP_STORE_EXT_POP, 8'h11);
    add(8'hdd, 8'h03, 8'h02, 8'h02, OP_STORE_DBL_POP, 8'h11);
    add(8'hd9, 8'h03, 8'h02, 8'h02, OP_STORE_SGL_POP, 8'h11);
    add(8'hdf, 8'h06, 8'h39, 8'h3f, OP_STORE_DECIMAL_POP, 8'h11);
    add(8'hdb, 8'h02, 8'h08, 8'h0d, OP_STORE_INT32, 8'h10);
    add(8'hdf, 8'h02, 8'h07, 8'h0a, OP_STORE_INT16, 8'h10);
    add(8'hdf, 8'h07, 8'h0a, 8'h0d, OP_STORE_INT64_POP, 8'h11);
    add(8'hdb, 8'h03, 8'h08, 8'h0d, OP_STORE_INT32_POP, 8'h11);
    add(8'hdf, 8'h03, 8'h07, 8'h0a, OP_STORE_INT16_POP, 8'h11);
    add(8'hd9, 8'h07, 8'h03, 8'h03, OP_STORE_CONTROL_WORD, 8'h90);
    add(8'hd9, 8'h06, 8'h0c, 8'h16, OP_STORE_ENVIRONMENT, 8'h90);
    add(8'hdd, 8'h07, 8'h04, 8'h04, OP_STORE_STATUS, 8'h90);
    add(8'hdf, 8'he0, 8'h02, 8'h02, OP_STORE_STATUS_ACC, 8'hc0);
    add(8'hdc, 8'h1d, 8'h04, 8'h09, OP_SUB_INTO_REG, 8'h00);
    add(8'hd8, 8'h1c, 8'h04, 8'h09, OP_SUB_INTO_TOP, 8'h00);
    add(8'hdc, 8'h04, 8'h04, 8'h09, OP_SUB_DBL, 8'h00);
    add(8'hd8, 8'h04, 8'h04, 8'h09, OP_SUB_SGL, 8'h00);
    add(8'hde, 8'h1d, 8'h04, 8'h09, OP_SUB_POP, 8'h01);
    add(8'hdc, 8'h1c, 8'h04, 8'h09, OP_SUBR_INTO_TOP, 8'h00);
    add(8'hd8, 8'h1d, 8'h04, 8'h09, OP_SUBR_INTO_REG, 8'h00);
    add(8'hdc, 8'h05, 8'h04, 8'h09, OP_SUBR_DBL, 8'h00);
    add(8'hd8, 8'h05, 8'h04, 8'h09, OP_SUBR_SGL, 8'h00);
    add(8'hde, 8'h1c, 8'h04, 8'h09, OP_SUBR_POP, 8'h01);
    add(8'hda, 8'h04, 8'h0e, 8'h1d, OP_ISUB32, 8'h00);
    add(8'hde, 8'h04, 8'h0e, 8'h1b, OP_ISUB16, 8'h00);
    add(8'hda, 8'h05, 8'h0e, 8'h1d, OP_ISUBR32, 8'h00);
    add(8'hde, 8'h05, 8'h0e, 8'h1b, OP_ISUBR16, 8'h00);
    add(8'hd9, 8'he4, 8'h04, 8'h04, OP_COMPARE_WITH_ZERO, 8'h20);
    add(8'hdd, 8'h1c, 8'h04, 8'h04, OP_UNORDERED_COMPARE, 8'h20);
    add(8'hdd, 8'h1d, 8'h04, 8'h04, OP_UNORDERED_COMPARE_POP, 8'h21);
    add(8'hda, 8'he9, 8'h04, 8'h04, OP_UNORDERED_COMPARE_POP_TWICE,
      8'h22);
    add(8'h9b, 8'h00, 8'h02, 8'h02, OP_WAIT_NOT_BUSY, 8'h00);
    add(8'hd9, 8'he5, 8'h04, 8'h04, OP_CLASSIFY_OPERAND, 8'h20);
    add(8'hd9, 8'h19, 8'h03, 8'h03, OP_EXCHANGE_WITH_TOP, 8'h00);
    add(8'hd9, 8'hf4, 8'h0b, 8'h10, OP_SPLIT_EXPONENT, 8'h07);
    add(8'hd9, 8'hf1, 8'h91, 8'h9a, OP_SCALED_LOG2, 8'h01);
    add(8'hd9, 8'hf9, 8'h83, 8'h85, OP_SCALED_LOG2_PLUS_ONE, 8'h01);
    void'($urandom(29));
    do_reset();
    // Least count, clamped most count, then random count, oor and gap
    for (int p = 0; p < 3; p++)
      foreach (tbl[i])
        run(i, 1'b0, (p == 0) ? 8'h00 : (p == 1) ? 8'hff : 8'($urandom),
          (p == 2) ? 1'($urandom) : 1'b0, 0, (p == 2) ? $urandom % 3 : 0);
    $display("test counts done");
    // Waiting forms with the unit busy for a few cycles
    foreach (tbl[i])
      run(i, 1'b1, 8'($urandom), 1'b0, $urandom % 4, 0);
    $display("test waiting done");
    // Out-of-range log argument, twice back to back
    foreach (tbl[i])
      if (tbl[i].op == OP_SCALED_LOG2_PLUS_ONE)
        repeat (2) run(i, 1'b0, 8'($urandom), 1'b1, 0, 0);
    $display("test fallback done");
    // Undecodable and reserved codes: refused, nothing else moves
    bad_code = '{16'hd9d7, 16'hded8, 16'hd8c0, 16'hdb05};
    foreach (bad_code[k])
    begin
      i_iu.send(bad_code[k][15:8], bad_code[k][7:0], 1'b0, 8'h00, 1'b0, 0);
      chk({reject_q, done_q}, 2'h2);
      @(posedge clk);
      #1;
      chk({reject_q, done_q, issue_ready_q, stack_top_q}, {3'h1, top_exp});
    end
    run(0, 1'b0, 8'h00, 1'b0, 0, 0);
    $display("test refusal done");
    // Reset after a completed split exponent push clears the pointer
    run(35, 1'b0, 8'h00, 1'b0, 0, 0);
    do_reset();
    run(4, 1'b0, 8'h00, 1'b0, 0, 1);
    $display("test second reset done");
    test_done();
  end
endmodule : tb
